// ===== verilog/vram_serial_host.sv
// Added by the designer: the register offsets and register access over Avalon-MM.
`timescale 1ns/1ns
module vram_serial_host
    import vram_host_pkg::*;
#(
    parameter int PAUSE_CYCLES = PAUSE_CYC,
    parameter int REFRESH_COUNT = INIT_REFRESH
) (
    // Clock and reset
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    // Avalon-MM slave
    input wire logic [4:0] i_AVS_ADDRESS,
    input wire logic i_AVS_READ,
    input wire logic i_AVS_WRITE,
    input wire logic [31:0] i_AVS_WRITEDATA,
    output logic [31:0] o_AVS_READDATA,
    output logic o_AVS_WAITREQUEST,
    // Memory control pins
    output logic o_ROW_STROBE_N,
    output logic o_COLUMN_STROBE_N,
    output logic o_TRANSFER_OUTPUT_ENABLE_N,
    output logic o_WRITE_MASK_WRITE_ENABLE_N,
    output logic o_SPECIAL_FUNCTION_INPUT,
    output logic [8:0] o_ADDRESS,
    // Random port data pins, used for the write transfer mask
    output logic [7:0] o_MASK_DATA,
    output logic o_MASK_DATA_OE_N,
    // Serial port pins
    output logic o_SERIAL_SHIFT_CLOCK,
    input wire logic [7:0] i_SERIAL_IO,
    output logic [7:0] o_SERIAL_IO,
    output logic o_SERIAL_IO_OE_N,
    input wire logic i_HALF_SELECT_FLAG
);
    // ************************************************************
    // Types and state
    // ************************************************************
    typedef enum logic [3:0] {
        ST_PAUSE = 4'h0,
        ST_REF_CAS = 4'h1,
        ST_REF_RAS = 4'h2,
        ST_REF_HOLD = 4'h3,
        ST_XF_SETUP = 4'h4,
        ST_XF_RAS = 4'h5,
        ST_XF_COL = 4'h6,
        ST_XF_REL = 4'h7,
        ST_PRECH = 4'h8,
        ST_IDLE = 4'h9,
        ST_SC_LOW = 4'ha,
        ST_SC_HIGH = 4'hb,
        ST_SC_WAIT = 4'hc
    } state_t;

    state_t state_reg, state_next;
    logic [11:0] cnt_reg, cnt_next;
    logic [3:0] ref_left_reg, ref_left_next;
    logic [2:0] cmd_reg, cmd_next;
    logic [8:0] row_reg, row_next;
    logic [8:0] tap_reg, tap_next;
    logic [7:0] mask_reg, mask_next;
    logic [7:0] wdata_reg, wdata_next;
    logic [7:0] rdata_reg, rdata_next;
    logic out_mode_reg, out_mode_next;
    logic tap_valid_reg, tap_valid_next;
    logic bnd_armed_reg, bnd_armed_next;
    logic bnd_active_reg, bnd_active_next;
    logic init_done_reg, init_done_next;
    logic err_reg, err_next;

    // Pin registers and their next values
    logic ras_n_reg, ras_n_next;
    logic cas_n_reg, cas_n_next;
    logic dtoe_n_reg, dtoe_n_next;
    logic we_n_reg, we_n_next;
    logic dsf_reg, dsf_next;
    logic [8:0] addr_reg, addr_next;
    logic [7:0] dq_reg, dq_next;
    logic dq_oe_n_reg, dq_oe_n_next;
    logic sc_reg, sc_next;
    logic sio_oe_n_reg, sio_oe_n_next;

    logic [8:0] pin_level;
    logic accept;
    logic err_set;
    logic is_xfer, is_write, is_split;
    logic in_ref, in_xf;

    // ************************************************************
    // Pin synchroniser for serial data and half flag
    // ************************************************************
    pin_sync3 #(.W(9)) u_sync (
        .i_clk(I_REF_CLK),
        .i_rst(I_RESET),
        .i_d({i_HALF_SELECT_FLAG, i_SERIAL_IO}),
        .o_level(pin_level)
    );

    // ************************************************************
    // Avalon-MM slave
    // ************************************************************
    // Writes other than STATUS stall while a cycle runs, so pins and
    // address never change under an open strobe
    assign o_AVS_WAITREQUEST = i_AVS_WRITE && (state_reg != ST_IDLE)
                               && (i_AVS_ADDRESS != REG_STATUS);
    assign accept = i_AVS_WRITE && !o_AVS_WAITREQUEST;

    // Read mux, unmapped offsets read zero
    always_comb begin
        o_AVS_READDATA = 32'h0000_0000;
        case (i_AVS_ADDRESS)
            REG_CMD: o_AVS_READDATA[2:0] = cmd_reg;
            REG_ADDR: begin
                o_AVS_READDATA[ADDR_ROW_LSB +: ADDR_W] = row_reg;
                o_AVS_READDATA[ADDR_TAP_LSB +: ADDR_W] = tap_reg;
            end
            REG_MASK: o_AVS_READDATA[7:0] = mask_reg;
            REG_SDATA: o_AVS_READDATA[7:0] = rdata_reg;
            REG_STATUS: begin
                o_AVS_READDATA[ST_BUSY_BIT] = (state_reg != ST_IDLE);
                o_AVS_READDATA[ST_INIT_BIT] = init_done_reg;
                o_AVS_READDATA[ST_OUTMODE_BIT] = out_mode_reg;
                o_AVS_READDATA[ST_TAPVALID_BIT] = tap_valid_reg;
                o_AVS_READDATA[ST_BNDARMED_BIT] = bnd_armed_reg;
                o_AVS_READDATA[ST_BNDACTIVE_BIT] = bnd_active_reg;
                o_AVS_READDATA[ST_HALF_BIT] = pin_level[8];
                o_AVS_READDATA[ST_ERR_BIT] = err_reg;
            end
            default: o_AVS_READDATA = 32'h0000_0000;
        endcase
    end

    // ************************************************************
    // Sequencer
    // ************************************************************
    // Next state, counters and tracked device state
    always_comb begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        ref_left_next = ref_left_reg;
        cmd_next = cmd_reg;
        row_next = row_reg;
        tap_next = tap_reg;
        mask_next = mask_reg;
        wdata_next = wdata_reg;
        rdata_next = rdata_reg;
        out_mode_next = out_mode_reg;
        tap_valid_next = tap_valid_reg;
        bnd_armed_next = bnd_armed_reg;
        bnd_active_next = bnd_active_reg;
        init_done_next = init_done_reg;
        err_set = 1'b0;
        if (accept && i_AVS_ADDRESS == REG_ADDR) begin
            row_next = i_AVS_WRITEDATA[ADDR_ROW_LSB +: ADDR_W];
            tap_next = i_AVS_WRITEDATA[ADDR_TAP_LSB +: ADDR_W];
        end
        if (accept && i_AVS_ADDRESS == REG_MASK) begin
            mask_next = i_AVS_WRITEDATA[7:0];
        end
        case (state_reg)
            ST_PAUSE: begin
                // Strobes and output enable held high during the pause
                if (cnt_reg == 12'h000) begin
                    ref_left_next = 4'(REFRESH_COUNT);
                    cmd_next = CMD_REFRESH;
                    state_next = ST_REF_CAS;
                end else begin
                    cnt_next = cnt_reg - 12'h001;
                end
            end
            ST_REF_CAS: state_next = ST_REF_RAS;
            ST_REF_RAS: state_next = ST_REF_HOLD;
            ST_REF_HOLD: begin
                if (cmd_reg == CMD_STOP_SET) begin
                    bnd_armed_next = 1'b1;
                end else begin
                    bnd_armed_next = 1'b0;
                    bnd_active_next = 1'b0;
                end
                cnt_next = 12'(PRECH_CYC);
                state_next = ST_PRECH;
            end
            ST_XF_SETUP: state_next = ST_XF_RAS;
            ST_XF_RAS: state_next = ST_XF_COL;
            ST_XF_COL: state_next = ST_XF_REL;
            ST_XF_REL: begin
                // Only full transfers move the port direction
                if (cmd_reg == CMD_FULL_READ) begin
                    out_mode_next = 1'b1;
                    tap_valid_next = 1'b1;
                end else if (cmd_reg == CMD_FULL_WRITE) begin
                    out_mode_next = 1'b0;
                    tap_valid_next = 1'b1;
                end else if (cmd_reg == CMD_SPLIT_READ && bnd_armed_reg) begin
                    bnd_active_next = 1'b1;
                end
                // Serial clock is held off longer after a write transfer
                cnt_next = is_write ? 12'(SRD_CYC) : 12'(PRECH_CYC);
                state_next = ST_PRECH;
            end
            ST_PRECH: begin
                if (cnt_reg > 12'h001) begin
                    cnt_next = cnt_reg - 12'h001;
                end else if (!init_done_reg && cmd_reg == CMD_REFRESH
                             && ref_left_reg > 4'h1) begin
                    ref_left_next = ref_left_reg - 4'h1;
                    state_next = ST_REF_CAS;
                end else if (!init_done_reg && cmd_reg == CMD_REFRESH) begin
                    // Fully masked write transfer sets a known state
                    cmd_next = CMD_FULL_WRITE;
                    state_next = ST_XF_SETUP;
                end else begin
                    init_done_next = 1'b1;
                    state_next = ST_IDLE;
                end
            end
            ST_IDLE: begin
                if (accept && i_AVS_ADDRESS == REG_CMD) begin
                    cmd_next = i_AVS_WRITEDATA[2:0];
                    case (i_AVS_WRITEDATA[2:0])
                        CMD_REFRESH, CMD_STOP_SET: state_next = ST_REF_CAS;
                        CMD_FULL_READ, CMD_FULL_WRITE:
                            state_next = ST_XF_SETUP;
                        CMD_SPLIT_READ, CMD_SPLIT_WRITE: begin
                            // Split needs a prior full transfer
                            if (tap_valid_reg) begin
                                state_next = ST_XF_SETUP;
                            end else begin
                                err_set = 1'b1;
                                cmd_next = cmd_reg;
                            end
                        end
                        default: cmd_next = cmd_reg;
                    endcase
                end else if (accept && i_AVS_ADDRESS == REG_SDATA) begin
                    // No shifting until a full transfer set the tap
                    if (tap_valid_reg) begin
                        wdata_next = i_AVS_WRITEDATA[7:0];
                        state_next = ST_SC_LOW;
                    end else begin
                        err_set = 1'b1;
                    end
                end
            end
            ST_SC_LOW: state_next = ST_SC_HIGH;
            ST_SC_HIGH: begin
                cnt_next = 12'(SYNC_WAIT_CYC);
                state_next = ST_SC_WAIT;
            end
            ST_SC_WAIT: begin
                if (cnt_reg > 12'h001) begin
                    cnt_next = cnt_reg - 12'h001;
                end else begin
                    // Data has passed the synchroniser by now
                    if (out_mode_reg) begin
                        rdata_next = pin_level[7:0];
                    end
                    state_next = ST_IDLE;
                end
            end
            default: state_next = ST_IDLE;
        endcase
        // Sticky error, a new error wins over a clear in the same cycle
        err_next = err_reg;
        if (accept && i_AVS_ADDRESS == REG_STATUS
            && i_AVS_WRITEDATA[ST_ERR_BIT]) begin
            err_next = 1'b0;
        end
        if (err_set) begin
            err_next = 1'b1;
        end
    end

    // ************************************************************
    // Pin decode from the next state
    // ************************************************************
    // Decoding the next state lets the pins come straight from flops
    always_comb begin
        is_xfer = (state_next == ST_XF_SETUP) || (state_next == ST_XF_RAS)
                  || (state_next == ST_XF_COL) || (state_next == ST_XF_REL);
        in_xf = is_xfer && (state_next != ST_XF_REL);
        in_ref = (state_next == ST_REF_CAS) || (state_next == ST_REF_RAS)
                 || (state_next == ST_REF_HOLD);
        is_write = (cmd_next == CMD_FULL_WRITE)
                   || (cmd_next == CMD_SPLIT_WRITE);
        is_split = (cmd_next == CMD_SPLIT_READ)
                   || (cmd_next == CMD_SPLIT_WRITE);
        ras_n_next = !((state_next == ST_XF_RAS) || (state_next == ST_XF_COL)
                       || (state_next == ST_XF_REL)
                       || (state_next == ST_REF_RAS)
                       || (state_next == ST_REF_HOLD));
        cas_n_next = !((state_next == ST_XF_COL) || (state_next == ST_XF_REL)
                       || in_ref); // Column strobe leads in refresh
        dtoe_n_next = !in_xf;
        we_n_next = !(in_xf && is_write);
        dsf_next = (is_xfer && is_split)
                   || (in_ref && cmd_next == CMD_STOP_SET);
        // Tap goes out with the column strobe
        addr_next = (state_next == ST_XF_COL || state_next == ST_XF_REL)
                    ? tap_next : row_next;
        // Init forces every block masked so the array stays untouched
        dq_next = init_done_reg ? mask_next : MASK_RST;
        dq_oe_n_next = !(((state_next == ST_XF_SETUP)
                         || (state_next == ST_XF_RAS)) && is_write);
        // Shift clock only moves outside transfers
        sc_next = (state_next == ST_SC_HIGH)
                  || (state_next == ST_SC_WAIT);
        sio_oe_n_next = !(!out_mode_reg && ((state_next == ST_SC_LOW)
                          || (state_next == ST_SC_HIGH)
                          || (state_next == ST_SC_WAIT)));
    end

    // ************************************************************
    // Registers
    // ************************************************************
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            state_reg <= ST_PAUSE;
            cnt_reg <= 12'(PAUSE_CYCLES);
            ref_left_reg <= 4'h0;
            cmd_reg <= CMD_NONE;
            row_reg <= ROW_RST;
            tap_reg <= TAP_RST;
            mask_reg <= MASK_RST;
            wdata_reg <= 8'h00;
            rdata_reg <= 8'h00;
            out_mode_reg <= 1'b0;
            tap_valid_reg <= 1'b0;
            bnd_armed_reg <= 1'b0;
            bnd_active_reg <= 1'b0;
            init_done_reg <= 1'b0;
            err_reg <= 1'b0;
            ras_n_reg <= 1'b1;
            cas_n_reg <= 1'b1;
            dtoe_n_reg <= 1'b1;
            we_n_reg <= 1'b1;
            dsf_reg <= 1'b0;
            addr_reg <= 9'h000;
            dq_reg <= 8'h00;
            dq_oe_n_reg <= 1'b1;
            sc_reg <= 1'b0;
            sio_oe_n_reg <= 1'b1;
        end else begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            ref_left_reg <= ref_left_next;
            cmd_reg <= cmd_next;
            row_reg <= row_next;
            tap_reg <= tap_next;
            mask_reg <= mask_next;
            wdata_reg <= wdata_next;
            rdata_reg <= rdata_next;
            out_mode_reg <= out_mode_next;
            tap_valid_reg <= tap_valid_next;
            bnd_armed_reg <= bnd_armed_next;
            bnd_active_reg <= bnd_active_next;
            init_done_reg <= init_done_next;
            err_reg <= err_next;
            ras_n_reg <= ras_n_next;
            cas_n_reg <= cas_n_next;
            dtoe_n_reg <= dtoe_n_next;
            we_n_reg <= we_n_next;
            dsf_reg <= dsf_next;
            addr_reg <= addr_next;
            dq_reg <= dq_next;
            dq_oe_n_reg <= dq_oe_n_next;
            sc_reg <= sc_next;
            sio_oe_n_reg <= sio_oe_n_next;
        end
    end

    // Pins straight from flops
    assign o_ROW_STROBE_N = ras_n_reg;
    assign o_COLUMN_STROBE_N = cas_n_reg;
    assign o_TRANSFER_OUTPUT_ENABLE_N = dtoe_n_reg;
    assign o_WRITE_MASK_WRITE_ENABLE_N = we_n_reg;
    assign o_SPECIAL_FUNCTION_INPUT = dsf_reg;
    assign o_ADDRESS = addr_reg;
    assign o_MASK_DATA = dq_reg;
    assign o_MASK_DATA_OE_N = dq_oe_n_reg;
    assign o_SERIAL_SHIFT_CLOCK = sc_reg;
    assign o_SERIAL_IO = wdata_reg;
    assign o_SERIAL_IO_OE_N = sio_oe_n_reg;
endmodule

// ===== verilog/vram_host_pkg.sv
package vram_host_pkg;

    // ************************************************************
    // Register map (byte offsets on the Avalon-MM slave)
    // ************************************************************
    localparam logic [4:0] REG_CMD = 5'h00;
    localparam logic [4:0] REG_ADDR = 5'h04;
    localparam logic [4:0] REG_MASK = 5'h08;
    localparam logic [4:0] REG_SDATA = 5'h0c;
    localparam logic [4:0] REG_STATUS = 5'h10;

    // ADDR register fields
    localparam int ADDR_ROW_LSB = 0;
    localparam int ADDR_TAP_LSB = 16;
    localparam int ADDR_W = 9;

    // STATUS register bit positions
    localparam int ST_BUSY_BIT = 0;
    localparam int ST_INIT_BIT = 1;
    localparam int ST_OUTMODE_BIT = 2;
    localparam int ST_TAPVALID_BIT = 3;
    localparam int ST_BNDARMED_BIT = 4;
    localparam int ST_BNDACTIVE_BIT = 5;
    localparam int ST_HALF_BIT = 6;
    localparam int ST_ERR_BIT = 7;

    // Reset values
    localparam logic [8:0] ROW_RST = 9'h000;
    localparam logic [8:0] TAP_RST = 9'h000;
    localparam logic [7:0] MASK_RST = 8'h00;

    // ************************************************************
    // Command codes written to REG_CMD
    // ************************************************************
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_REFRESH = 3'h1;
    localparam logic [2:0] CMD_STOP_SET = 3'h2;
    localparam logic [2:0] CMD_FULL_READ = 3'h3;
    localparam logic [2:0] CMD_FULL_WRITE = 3'h4;
    localparam logic [2:0] CMD_SPLIT_READ = 3'h5;
    localparam logic [2:0] CMD_SPLIT_WRITE = 3'h6;

    // ************************************************************
    // Timing, 10 MHz reference clock
    // ************************************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int PAUSE_US = 200;
    localparam int PAUSE_CYC = (PAUSE_US * 1000 + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int INIT_REFRESH = 8;
    localparam int PRECH_NS = 100;
    localparam int PRECH_CYC = (PRECH_NS + CLK_PERIOD_NS - 1)
                               / CLK_PERIOD_NS;
    localparam int SRD_NS = 200;
    localparam int SRD_CYC = (SRD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_WAIT_CYC = 4;

endpackage

// ===== verilog/pin_sync3.sv
`timescale 1ns/1ns
module pin_sync3 #(
    parameter int W = 9
) (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Asynchronous pins in, filtered level out
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_level
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    logic [W-1:0] level_next;

    // A bit only moves once stages two and three agree, stage one is
    // left alone so metastability never reaches the comparison
    always_comb begin
        level_next = (s3_reg & ~(s2_reg ^ s3_reg))
                   | (level_reg & (s2_reg ^ s3_reg));
    end

    // Three-flop chain plus filtered level
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_reg <= '0;
        end else begin
            s1_reg <= i_d;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign o_level = level_reg;
endmodule

// ===== tb/vram_dev_model.sv
`timescale 1ns/1ns
module vram_dev_model (
    // Strobes and address
    input wire logic i_ras_n,
    input wire logic i_cas_n,
    input wire logic i_dtoe_n,
    input wire logic i_we_n,
    input wire logic i_dsf,
    input wire logic [8:0] i_addr,
    // Serial port
    input wire logic i_sc,
    input wire logic [7:0] i_sio,
    output logic [7:0] o_sio,
    output logic o_qsf
);
    logic [7:0] mem [512];
    logic [8:0] ptr;
    logic [7:0] stap;
    logic out_mode = 1'b0;
    logic xfer = 1'b0;
    logic split = 1'b0;
    initial o_sio = 8'h00;
    assign o_qsf = ptr[8];
    // Row strobe fall decodes the cycle; row data is a known pattern
    always @(negedge i_ras_n) begin
        xfer = i_cas_n && !i_dtoe_n;
        if (xfer) split = i_dsf;
        if (xfer && !i_dsf) out_mode = i_we_n;
        if (xfer && i_we_n) for (int i = 0; i < 512; i++)
            if (!i_dsf || i[8] != ptr[8]) mem[i] = 8'(i) ^ i_addr[7:0];
    end
    // Tap is the column at column strobe fall of a transfer; the address
    // pins change in that same step, so look a moment later
    always @(negedge i_cas_n) begin
        #1;
        if (xfer && !i_ras_n) begin
            if (split) stap = i_addr[7:0];
            else ptr = i_addr;
        end
    end
    // Released lines show the inverse of the last value, never a stale copy
    always @(posedge i_sc) begin
        if (out_mode) o_sio <= mem[ptr];
        else begin
            mem[ptr] = i_sio;
            o_sio <= ~o_sio;
        end
        // In split mode the top of a half hands over to the other tap
        if (split && ptr[7:0] == 8'hff) ptr = {~ptr[8], stap};
        else ptr = ptr + 9'h001;
    end
endmodule

// ===== tb/vram_serial_host_properties.sv
`timescale 1ns/1ns
module vram_serial_host_properties #(
    parameter int PAUSE_CYCLES = 2000,
    parameter int REFRESH_COUNT = 8
) (
    input wire logic I_REF_CLK,
    input wire logic I_RESET,
    input wire logic o_ROW_STROBE_N,
    input wire logic o_COLUMN_STROBE_N,
    input wire logic o_TRANSFER_OUTPUT_ENABLE_N,
    input wire logic o_WRITE_MASK_WRITE_ENABLE_N,
    input wire logic o_MASK_DATA_OE_N,
    input wire logic o_SERIAL_SHIFT_CLOCK,
    input wire logic [7:0] o_SERIAL_IO,
    input wire logic o_SERIAL_IO_OE_N
);
    int cyc;
    int falls;
    default clocking @(posedge I_REF_CLK); endclocking
    default disable iff (I_RESET);
    // Cycles since reset and row strobe falls, both saturating
    always_ff @(posedge I_REF_CLK or posedge I_RESET) begin
        if (I_RESET) begin
            cyc <= 0;
            falls <= 0;
        end else begin
            if (cyc < PAUSE_CYCLES) cyc <= cyc + 1;
            if ($fell(o_ROW_STROBE_N) && falls < 99) falls <= falls + 1;
        end
    end
    pause_quiet_a: assert property (cyc < PAUSE_CYCLES |->
        o_ROW_STROBE_N && o_TRANSFER_OUTPUT_ENABLE_N) else $error("pause");
    init_refresh_a: assert property ($fell(o_ROW_STROBE_N) &&
        falls < REFRESH_COUNT |-> !o_COLUMN_STROBE_N) else $error("refresh");
    init_dtoe_a: assert property (falls < REFRESH_COUNT |->
        o_TRANSFER_OUTPUT_ENABLE_N) else $error("init dtoe");
    xfer_tap_a: assert property ($fell(o_ROW_STROBE_N) &&
        !o_TRANSFER_OUTPUT_ENABLE_N |-> o_COLUMN_STROBE_N ##1
        $fell(o_COLUMN_STROBE_N)) else $error("tap strobe");
    wt_mask_a: assert property ($fell(o_ROW_STROBE_N) &&
        !o_TRANSFER_OUTPUT_ENABLE_N && !o_WRITE_MASK_WRITE_ENABLE_N
        |-> !o_MASK_DATA_OE_N) else $error("mask");
    sc_static_a: assert property (!o_ROW_STROBE_N |->
        $stable(o_SERIAL_SHIFT_CLOCK)) else $error("sc moved");
    srd_gap_a: assert property ($rose(o_ROW_STROBE_N) |->
        !$rose(o_SERIAL_SHIFT_CLOCK) [*2]) else $error("sc early");
    sio_hold_a: assert property ($rose(o_SERIAL_SHIFT_CLOCK) &&
        !o_SERIAL_IO_OE_N |-> $stable(o_SERIAL_IO)) else $error("sio");
    xfer_quiet_a: assert property (!o_TRANSFER_OUTPUT_ENABLE_N |->
        o_SERIAL_IO_OE_N) else $error("sio in xfer");
endmodule
bind vram_serial_host vram_serial_host_properties #(
    .PAUSE_CYCLES(PAUSE_CYCLES), .REFRESH_COUNT(REFRESH_COUNT)) chk_i (.*);

// ===== tb/vram_serial_host_tb.sv
`timescale 1ns/1ns
module vram_serial_host_tb;
    import vram_host_pkg::*;
    localparam int PAUSE = 20;
    logic clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0, wq, half_select_flag, dsf;
    logic [4:0] adr = 5'h00;
    logic [31:0] wd = 32'h0, rdat, s;
    logic row_n, cas_n, dtoe_n, we_n, sc, oe_n;
    logic [8:0] maddr;
    logic [7:0] h_sio, d_sio, serial_io_pins;
    int failures = 0, checked = 0, cyc = 0, first_fall = 0, falls = 0;
    assign serial_io_pins = oe_n ? d_sio : h_sio;
    // ************************************************************
    // Clock, sampling and pin monitors
    // ************************************************************
    initial forever #50 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    always @(negedge row_n) begin
        if (falls == 0) first_fall = cyc;
        falls++;
    end
    vram_serial_host #(.PAUSE_CYCLES(PAUSE), .REFRESH_COUNT(8)) uut (
        .I_REF_CLK(clk), .I_RESET(rst), .i_AVS_ADDRESS(adr),
        .i_AVS_READ(rd), .i_AVS_WRITE(wr), .i_AVS_WRITEDATA(wd),
        .o_AVS_READDATA(rdat), .o_AVS_WAITREQUEST(wq),
        .o_ROW_STROBE_N(row_n), .o_COLUMN_STROBE_N(cas_n),
        .o_TRANSFER_OUTPUT_ENABLE_N(dtoe_n),
        .o_WRITE_MASK_WRITE_ENABLE_N(we_n), .o_SPECIAL_FUNCTION_INPUT(dsf),
        .o_ADDRESS(maddr), .o_MASK_DATA(), .o_MASK_DATA_OE_N(),
        .o_SERIAL_SHIFT_CLOCK(sc), .i_SERIAL_IO(serial_io_pins), .o_SERIAL_IO(h_sio),
        .o_SERIAL_IO_OE_N(oe_n), .i_HALF_SELECT_FLAG(half_select_flag));
    vram_dev_model dev (.i_ras_n(row_n), .i_cas_n(cas_n), .i_dtoe_n(dtoe_n),
        .i_we_n(we_n), .i_dsf(dsf), .i_addr(maddr), .i_sc(sc), .i_sio(serial_io_pins),
        .o_sio(d_sio), .o_qsf(half_select_flag));
    // ************************************************************
    // Bus cycles and comparison
    // ************************************************************
    // Request held until waitrequest is seen low at a rising edge
    task automatic av(input logic w, input logic [4:0] a,
        input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        adr <= a;
        wd <= d;
        if (w) wr <= 1'b1;
        else rd <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (wq !== 1'b0 && n < 9999);
        q = rdat;
        if (n >= 9999) failures++;
        wr <= 1'b0;
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Busy is polled, never assumed to last a fixed time
    task automatic xfer(input logic [2:0] c, input logic [8:0] r, t);
        av(1'b1, REG_ADDR, {7'h0, t, 7'h0, r}, s);
        av(1'b1, REG_CMD, {29'h0, c}, s);
        for (int n = 0; n < 200; n++) begin
            av(1'b0, REG_STATUS, 32'h0, s);
            if (s[ST_BUSY_BIT] === 1'b0) break;
        end
        chk({31'h0, s[ST_BUSY_BIT]}, 32'h0);
    endtask
    task automatic shift(input logic [7:0] d, output logic [31:0] q);
        xfer(CMD_NONE, 9'h000, 9'h000);
        av(1'b1, REG_SDATA, {24'h0, d}, q);
        xfer(CMD_NONE, 9'h000, 9'h000);
        av(1'b0, REG_SDATA, 32'h0, q);
    endtask
    task automatic stb(input int b, input logic e);
        av(1'b0, REG_STATUS, 32'h0, s);
        chk({31'h0, s[b]}, {31'h0, e});
    endtask
    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_init();
        for (int n = 0; n < 400 && s[ST_INIT_BIT] !== 1'b1; n++)
            av(1'b0, REG_STATUS, 32'h0, s);
        chk({31'h0, s[ST_INIT_BIT]}, 32'h1);
        chk(falls, 9);
        chk({31'h0, first_fall >= PAUSE + 4}, 32'h1);
        chk({31'h0, dev.out_mode}, 32'h0);
        $display("init done");
    endtask
    // Read from near the top so the pointer wraps
    task automatic t_read();
        xfer(CMD_FULL_READ, 9'h003, 9'h1fe);
        stb(ST_OUTMODE_BIT, 1'b1);
        for (int i = 0; i < 3; i++) begin
            shift(8'h00, s);
            chk(s, {24'h0, 8'(9'h1fe + i) ^ 8'h03});
            stb(ST_HALF_BIT, i == 0);
        end
        xfer(CMD_FULL_READ, 9'h007, 9'h005);
        shift(8'h00, s);
        chk(s, 32'h02);
        $display("read done");
    endtask
    task automatic t_write();
        xfer(CMD_FULL_WRITE, 9'h001, 9'h010);
        stb(ST_OUTMODE_BIT, 1'b0);
        shift(8'ha5, s);
        chk({24'h0, dev.mem[9'h010]}, 32'ha5);
        $display("write done");
    endtask
    // Stop set arms, split read activates, refresh clears
    task automatic t_bound();
        xfer(CMD_STOP_SET, 9'h00f, 9'h000);
        stb(ST_BNDARMED_BIT, 1'b1);
        stb(ST_BNDACTIVE_BIT, 1'b0);
        xfer(CMD_SPLIT_READ, 9'h002, 9'h020);
        stb(ST_BNDACTIVE_BIT, 1'b1);
        stb(ST_OUTMODE_BIT, 1'b0);
        stb(ST_ERR_BIT, 1'b0);
        xfer(CMD_REFRESH, 9'h000, 9'h000);
        stb(ST_BNDACTIVE_BIT, 1'b0);
        av(1'b0, 5'h14, 32'h0, s);
        chk(s, 32'h0);
        $display("bound done");
    endtask
    task automatic close_out();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_init();
        t_read();
        t_write();
        t_bound();
        close_out();
    end
    // Watchdog, far beyond the expected run
    initial begin
        #5000000;
        failures++;
        close_out();
    end
endmodule
